// >>> rtl/fpmenu_pkg.sv
// Constants, page encoding and limits for the front panel parameter menu
// Function
// - Each Data press moves to the next page, its lamp and its value.
// - Mode page steps to analogue page, then rate page, then layer page.
// - Holding Data keeps cycling pages; release stops on the shown page.
// - Ten idle seconds revert to layer view in sequence control, else rate.
// - Unconfirmed edits are dropped at the idle timeout.
// - Increment and Decrement ignored while shutter open, failed or recovering.
// - Shutter lamps flash during power fail recovery.
// - Holding Increment or Decrement repeats the change at a fast rate.
// - Layer and crystal values wrap at both ends.
// - All other values saturate at their minimum and maximum.
// - One press changes the shown value by one least significant unit.
// - Data on an edited value stores it, then advances the page.
// - Layer selector: layers 1 to 11, then sequence codes 12 1 to 19 6.
// - Layer page steps through six parameters; four more presses return.
// - Crystal select takes only 1 or 2.
// - Termination thickness zero means manual: shutter closes only on Run.
// - Crystal mode 1 is backup, 2 is layer select.
// - Analogue mode ranges 0 to 39 and keeps its last or default value.
// - Faulty parameter store at power up shows fault code, uses defaults.
package fpmenu_pkg;

    localparam int CLK_HZ       = 40_000_000;
    localparam int DEBOUNCE_MS  = 10;
    localparam int HOLD_MS      = 500;
    localparam int REPEAT_MS    = 50;
    localparam int CYCLE_MS     = 400;
    localparam int IDLE_S       = 10;
    localparam int FLASH_MS     = 250;

    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int HOLD_CYC     = CLK_HZ / 1000 * HOLD_MS;
    localparam int REPEAT_CYC   = CLK_HZ / 1000 * REPEAT_MS;
    localparam int CYCLE_CYC    = CLK_HZ / 1000 * CYCLE_MS;
    localparam int IDLE_CYC     = CLK_HZ * IDLE_S;
    localparam int FLASH_CYC    = CLK_HZ / 1000 * FLASH_MS;

    localparam int NPAGE = 10;
    localparam int VW    = 16;

    typedef enum logic [3:0] {
        PG_LAYER, PG_DENSITY, PG_ZVALUE, PG_TERMINATE, PG_TOOLING,
        PG_XTAL, PG_USAGE, PG_MODE, PG_ANALOG, PG_RATE
    } fpmenu_page_t;

    // Layer index 0..10 is layer 1..11; 11.. is sequence (12..19, step 1..6)
    localparam logic [VW-1:0] LAYER_SINGLE = 16'h000b;
    localparam logic [VW-1:0] LAYER_MAX    = 16'h003a;
    localparam logic [VW-1:0] XTAL_MIN     = 16'h0001;
    localparam logic [VW-1:0] XTAL_MAX     = 16'h0002;
    localparam logic [VW-1:0] MODE_BACKUP  = 16'h0001;
    localparam logic [VW-1:0] MODE_LAYSEL  = 16'h0002;
    localparam logic [VW-1:0] ANALOG_MAX   = 16'h0027;
    localparam logic [VW-1:0] VAL_MAX      = 16'h270f;
    localparam logic [VW-1:0] MEM_FAULT_CODE = 16'h00e3;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_SHOWN  = 8'h08;
    localparam logic [7:0] OFF_SEL    = 8'h0c;
    localparam logic [7:0] OFF_PARAM  = 8'h10;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [3:0] RST_SEL     = 4'h0;

    function automatic logic [VW-1:0] page_min(input fpmenu_page_t p);
        case (p)
            PG_XTAL, PG_MODE, PG_DENSITY, PG_TOOLING: page_min = 16'h0001;
            default:                                  page_min = 16'h0000;
        endcase
    endfunction

    function automatic logic [VW-1:0] page_max(input fpmenu_page_t p);
        case (p)
            PG_LAYER:  page_max = LAYER_MAX;
            PG_XTAL:   page_max = XTAL_MAX;
            PG_MODE:   page_max = MODE_LAYSEL;
            PG_ANALOG: page_max = ANALOG_MAX;
            default:   page_max = VAL_MAX;
        endcase
    endfunction

    function automatic logic [VW-1:0] page_def(input fpmenu_page_t p);
        case (p)
            PG_DENSITY: page_def = 16'h0064;
            PG_ZVALUE:  page_def = 16'h0372;
            PG_TOOLING: page_def = 16'h0064;
            PG_XTAL:    page_def = XTAL_MIN;
            PG_MODE:    page_def = MODE_BACKUP;
            default:    page_def = 16'h0000;
        endcase
    endfunction

endpackage

// >>> rtl/fpmenu_top.sv
// Front panel menu controller with AXI4-Lite status and control
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module fpmenu_top
    import fpmenu_pkg::*;
#(
    parameter int DEBOUNCE = fpmenu_pkg::DEBOUNCE_CYC,
    parameter int HOLD     = fpmenu_pkg::HOLD_CYC,
    parameter int REPEAT   = fpmenu_pkg::REPEAT_CYC,
    parameter int CYCLE    = fpmenu_pkg::CYCLE_CYC,
    parameter int IDLE     = fpmenu_pkg::IDLE_CYC,
    parameter int FLASH    = fpmenu_pkg::FLASH_CYC
)(
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // Buttons, active high while pressed
    input  wire logic                     btn_data,
    input  wire logic                     btn_inc,
    input  wire logic                     btn_dec,
    input  wire logic                     btn_run,
    // Process state
    input  wire logic                     shutter_open,
    input  wire logic                     sensor_fail_close,
    input  wire logic                     pf_recovery,
    input  wire logic                     nvm_fault,
    input  wire logic                     term_reached,
    input  wire logic [fpmenu_pkg::VW-1:0] rate_value,
    // Panel outputs
    output logic [fpmenu_pkg::NPAGE-1:0]  page_led,
    output logic [fpmenu_pkg::VW-1:0]     shown_value,
    output logic                          memory_fault_code,
    output logic                          shutter_led_flash,
    output logic                          manual_mode,
    output logic                          shutter_close,
    output logic                          seq_active,
    // AXI4-Lite slave
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);
    import fpmenu_pkg::*;

    localparam int NB = 4, BI_DATA = 0, BI_INC = 1, BI_DEC = 2, BI_RUN = 3;

    logic [NB-1:0]   raw;
    logic [NB-1:0]   stable_r;
    logic [31:0]     deb_cnt_r [NB];
    logic [31:0]     hold_cnt_r [NB];
    logic [NB-1:0]   act_r;
    logic [NB-1:0]   press_r;
    logic [31:0]     idle_cnt_r;
    logic [31:0]     flash_cnt_r;
    fpmenu_page_t    page_r;
    fpmenu_page_t    page_nxt;
    logic [VW-1:0]   param_r [NPAGE];
    logic [VW-1:0]   shown_r;
    logic            edited_r;
    logic            init_r;
    logic            lock_sw_r;
    logic [3:0]      sel_r;
    logic            edit_lock;
    logic            idle_hit;
    logic            aw_got_r;
    logic            w_got_r;
    logic [7:0]      awaddr_r;
    logic [31:0]     wdata_r;
    logic [3:0]      wstrb_r;

    assign raw = {btn_run, btn_dec, btn_inc, btn_data};

    function automatic fpmenu_page_t next_page(input fpmenu_page_t p);
        if (p == PG_RATE)
            next_page = PG_LAYER;
        else
            next_page = fpmenu_page_t'(p + 4'h1);
    endfunction

    function automatic logic [VW-1:0] step(input fpmenu_page_t p, input logic [VW-1:0] v,
                                           input logic up);
        logic wrap;
        wrap = (p == PG_LAYER) || (p == PG_XTAL);
        if (up)
        begin
            if (v >= page_max(p))
                step = wrap ? page_min(p) : page_max(p);
            else
                step = v + 16'h0001;
        end
        else
        begin
            if (v <= page_min(p))
                step = wrap ? page_max(p) : page_min(p);
            else
                step = v - 16'h0001;
        end
    endfunction

    // Debounce; pulse on clean press and on each repeat after the hold delay
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < NB; i++)
        begin
            act_r[i]   <= 1'b0;
            press_r[i] <= 1'b0;
            if (!rst_n)
            begin
                stable_r[i]   <= 1'b0;
                deb_cnt_r[i]  <= 32'h0;
                hold_cnt_r[i] <= 32'h0;
            end
            else if (raw[i] != stable_r[i])
            begin
                if (deb_cnt_r[i] >= 32'(DEBOUNCE - 1))
                begin
                    stable_r[i]   <= raw[i];
                    deb_cnt_r[i]  <= 32'h0;
                    hold_cnt_r[i] <= 32'h0;
                    act_r[i]      <= raw[i];
                    press_r[i]    <= raw[i];
                end
                else
                    deb_cnt_r[i] <= deb_cnt_r[i] + 32'h1;
            end
            else
            begin
                deb_cnt_r[i] <= 32'h0;
                if (stable_r[i])
                begin
                    // Data cycles pages slower than the value repeat
                    if (hold_cnt_r[i] >= 32'(HOLD + ((i == BI_DATA) ? CYCLE : REPEAT) - 1))
                    begin
                        hold_cnt_r[i] <= 32'(HOLD);
                        act_r[i]      <= 1'b1;
                    end
                    else
                        hold_cnt_r[i] <= hold_cnt_r[i] + 32'h1;
                end
            end
        end
    end

    assign edit_lock = shutter_open | sensor_fail_close | pf_recovery | lock_sw_r;
    assign idle_hit  = (idle_cnt_r == 32'(IDLE - 1));

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || (|act_r) || (|stable_r))
            idle_cnt_r <= 32'h0;
        else if (idle_cnt_r != 32'(IDLE))
            idle_cnt_r <= idle_cnt_r + 32'h1;
    end

    // Page sequence: layer, six layer parameters, mode, analogue, rate, layer
    assign page_nxt = next_page(page_r);

    // Menu state: page, shown value and edit flag
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            page_r   <= PG_RATE;
            shown_r  <= 16'h0000;
            edited_r <= 1'b0;
        end
        else if (act_r[BI_DATA])
        begin
            page_r   <= page_nxt;
            shown_r  <= (page_nxt == PG_RATE) ? rate_value : param_r[page_nxt];
            edited_r <= 1'b0;
        end
        else if (idle_hit)
        begin
            // Reload from the store so any uncommitted edit is lost
            page_r   <= seq_active ? PG_LAYER : PG_RATE;
            shown_r  <= seq_active ? param_r[PG_LAYER] : rate_value;
            edited_r <= 1'b0;
        end
        else if ((act_r[BI_INC] ^ act_r[BI_DEC]) && !edit_lock
                 && (page_r != PG_RATE) && (page_r != PG_USAGE))
        begin
            shown_r  <= step(page_r, shown_r, act_r[BI_INC]);
            edited_r <= 1'b1;
        end
        else if (page_r == PG_RATE)
            shown_r <= rate_value;
    end

    // Parameter store; defaults at reset and again after a store fault
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            init_r <= 1'b1;
            for (int p = 0; p < NPAGE; p++)
                param_r[p] <= page_def(fpmenu_page_t'(p));
        end
        else
        begin
            init_r <= 1'b0;
            if (init_r && nvm_fault)
            begin
                for (int p = 0; p < NPAGE; p++)
                    param_r[p] <= page_def(fpmenu_page_t'(p));
            end
            else if (act_r[BI_DATA] && edited_r)
                param_r[page_r] <= shown_r;
        end
    end

    // Fault indication holds until any clean press
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            memory_fault_code <= 1'b0;
        else if (init_r && nvm_fault)
            memory_fault_code <= 1'b1;
        else if (|press_r)
            memory_fault_code <= 1'b0;
    end

    // Recovery flash
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !pf_recovery)
        begin
            flash_cnt_r       <= 32'h0;
            shutter_led_flash <= 1'b0;
        end
        else if (flash_cnt_r >= 32'(FLASH - 1))
        begin
            flash_cnt_r       <= 32'h0;
            shutter_led_flash <= ~shutter_led_flash;
        end
        else
            flash_cnt_r <= flash_cnt_r + 32'h1;
    end

    // Close on Run, or on termination unless manual
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            manual_mode   <= 1'b0;
            shutter_close <= 1'b0;
            seq_active    <= 1'b0;
        end
        else
        begin
            manual_mode   <= (param_r[PG_TERMINATE] == 16'h0000);
            shutter_close <= press_r[BI_RUN]
                             || (term_reached && (param_r[PG_TERMINATE] != 16'h0000));
            seq_active    <= (param_r[PG_LAYER] >= LAYER_SINGLE);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            page_led    <= '0;
            shown_value <= 16'h0000;
        end
        else
        begin
            page_led    <= NPAGE'(1) << page_r;
            shown_value <= memory_fault_code ? MEM_FAULT_CODE : shown_r;
        end
    end

    // AXI4-Lite write: AW and W in either order, answer after both
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            lock_sw_r     <= 1'b0;
            sel_r         <= RST_SEL;
        end
        else
        begin
            s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid)
            begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                case (awaddr_r)
                    OFF_CTRL:
                        if (wstrb_r[0])
                            lock_sw_r <= wdata_r[0];
                    OFF_SEL:
                        if (wstrb_r[0])
                            sel_r <= wdata_r[3:0];
                    OFF_STATUS, OFF_SHOWN, OFF_PARAM: ;
                    default:
                        s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read: data one cycle after the address is taken
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    OFF_CTRL:   s_axi_rdata <= {31'h0, lock_sw_r};
                    OFF_STATUS: s_axi_rdata <= {20'h0, memory_fault_code, seq_active,
                                                manual_mode, pf_recovery, edit_lock,
                                                edited_r, 2'b00, page_r};
                    OFF_SHOWN:  s_axi_rdata <= {16'h0, shown_r};
                    OFF_SEL:    s_axi_rdata <= {28'h0, sel_r};
                    OFF_PARAM:  s_axi_rdata <= (sel_r < 4'(NPAGE)) ? {16'h0, param_r[sel_r]}
                                                                    : 32'h0;
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // fpmenu_top

// >>> tb/fpmenu_assertions.sv
// Port level checker for the front panel menu controller
`timescale 1ns/100ps
module fpmenu_assertions
    import fpmenu_pkg::*;
#(
    parameter int FLASH = 4
)(
    // Clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    // Inputs
    input wire logic                    btn_data,
    input wire logic                    btn_run,
    input wire logic                    shutter_open,
    input wire logic                    sensor_fail_close,
    input wire logic                    pf_recovery,
    input wire logic                    nvm_fault,
    input wire logic                    s_axi_bready,
    // Outputs
    input wire logic [NPAGE-1:0]        page_led,
    input wire logic [VW-1:0]           shown_value,
    input wire logic                    memory_fault_code,
    input wire logic                    shutter_led_flash,
    input wire logic                    manual_mode,
    input wire logic                    shutter_close,
    input wire logic                    s_axi_bvalid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic lock = shutter_open | sensor_fail_close | pf_recovery;
    a_led_onehot: assert property ($onehot0(page_led))
        else $error("page lamps not one hot");
    a_data_step: assert property (!memory_fault_code && $rose(btn_data) ##1 btn_data[*3]
        |-> ##[0:6] $changed(page_led)) else $error("data press did not move page");
    // Lamps and value lag the page by a cycle, so the lock must be two cycles old
    a_edit_lock: assert property ($past(lock, 2) && $past(lock) && lock && $stable(page_led)
        && !page_led[9] && !$past(memory_fault_code) |-> $stable(shown_value))
        else $error("value changed while locked");
    a_flash_off: assert property (!pf_recovery && !$past(pf_recovery) |-> !shutter_led_flash)
        else $error("flash without recovery");
    a_flash_rate: assert property (not ((pf_recovery && $stable(shutter_led_flash))[*6]))
        else $error("flash lamp stuck in recovery");
    a_manual_hold: assert property ((manual_mode && !btn_run)[*8] |-> !shutter_close)
        else $error("automatic close in manual mode");
    a_run_close: assert property ($rose(btn_run) ##1 btn_run[*3] |-> ##[0:6] shutter_close)
        else $error("run press did not close");
    a_fault_set: assert property ($rose(rst_n) && nvm_fault |-> ##[1:3] memory_fault_code)
        else $error("store fault not flagged");
    a_fault_shown: assert property (memory_fault_code && $past(memory_fault_code)
        |-> shown_value == MEM_FAULT_CODE) else $error("fault code not shown");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    c_fault: cover property ($rose(memory_fault_code));
    c_flash: cover property ($rose(shutter_led_flash));
    c_close: cover property ($rose(shutter_close));
endmodule // fpmenu_assertions

bind fpmenu_top fpmenu_assertions #(.FLASH(FLASH)) u_chk (.clk_sys, .rst_n, .btn_data, .btn_run,
    .shutter_open, .sensor_fail_close, .pf_recovery, .nvm_fault, .s_axi_bready, .page_led,
    .shown_value, .memory_fault_code, .shutter_led_flash, .manual_mode, .shutter_close,
    .s_axi_bvalid);

// >>> tb/fpmenu_panel_model.sv
// Operator model that presses the panel buttons
`timescale 1ns/100ps
module fpmenu_panel_model (
    // Clock
    input  wire logic clk_sys,
    // Buttons
    output logic      btn_data,
    output logic      btn_inc,
    output logic      btn_dec,
    output logic      btn_run
);
    logic [3:0] held = 4'h0;
    assign {btn_run, btn_dec, btn_inc, btn_data} = held;
    // Press held past debounce, then a gap so the release settles
    task automatic press(input int b, input int n);
        @(posedge clk_sys);
        held <= 4'h1 << b;
        repeat (n) @(posedge clk_sys);
        held <= 4'h0;
        repeat (10) @(posedge clk_sys);
    endtask
endmodule // fpmenu_panel_model

// >>> tb/fpmenu_top_tb.sv
// Self-checking bench for the front panel menu controller
`timescale 1ns/100ps
module fpmenu_top_tb;
    import fpmenu_pkg::*;
    localparam int B_DATA = 0, B_INC = 1, B_DEC = 2, B_RUN = 3;
    logic              clk_sys, rst_n, shutter_open, sensor_fail_close, pf_recovery;
    logic              nvm_fault, term_reached, btn_data, btn_inc, btn_dec, btn_run;
    logic [VW-1:0]     rate_value, shown_value;
    logic [NPAGE-1:0]  page_led;
    logic              memory_fault_code, shutter_led_flash, manual_mode, shutter_close, seq_active;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int                fails = 0;
    int                n_tests = 0;

    fpmenu_top #(.DEBOUNCE(4), .HOLD(20), .REPEAT(3), .CYCLE(5), .IDLE(200), .FLASH(4)) uut (
        .clk_sys, .rst_n, .btn_data, .btn_inc, .btn_dec, .btn_run, .shutter_open,
        .sensor_fail_close, .pf_recovery, .nvm_fault, .term_reached, .rate_value, .page_led,
        .shown_value, .memory_fault_code, .shutter_led_flash, .manual_mode, .shutter_close,
        .seq_active, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    fpmenu_panel_model pm (.clk_sys, .btn_data, .btn_inc, .btn_dec, .btn_run);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tap(input int b, input logic [31:0] e, input string nm);
        pm.press(b, 8);
        chk(nm, e, shown_value);
    endtask
    task automatic goto(input int p);
        for (int k = 0; k < 12 && page_led[p] !== 1'b1; k++)
            pm.press(B_DATA, 8);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", RESP_OKAY, s_axi_bresp);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Whole run needs about 1600 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        complete_run();
    end
    initial
    begin
        {rst_n, shutter_open, sensor_fail_close, pf_recovery, nvm_fault, term_reached} = 6'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        rate_value = 16'h0123;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("rate shown", 16'h0123, shown_value);
        chk("manual", 1, manual_mode);
        term_reached <= 1'b1;
        rate_value <= 16'h0456;
        repeat (6) @(posedge clk_sys);
        chk("auto close", 0, shutter_close);
        chk("rate follows", 16'h0456, shown_value);
        term_reached <= 1'b0;
        pm.press(B_RUN, 8);
        goto(7);
        chk("mode", 1, shown_value);
        tap(B_INC, 2, "mode up");
        tap(B_INC, 2, "mode max");
        pm.press(B_DATA, 8);
        chk("analog page", 10'h100, page_led);
        tap(B_DEC, 0, "analog min");
        pm.press(B_DATA, 8);
        chk("rate page", 10'h200, page_led);
        pm.press(B_DATA, 8);
        chk("layer page", 10'h001, page_led);
        tap(B_DEC, 16'h003a, "layer wrap down");
        tap(B_INC, 0, "layer wrap up");
        tap(B_DEC, 16'h003a, "last sequence");
        pm.press(B_DATA, 8);
        chk("density page", 10'h002, page_led);
        chk("density", 16'h0064, shown_value);
        chk("sequence", 1, seq_active);
        tap(B_DEC, 16'h0063, "step down");
        tap(B_INC, 16'h0064, "step up");
        tap(B_DEC, 16'h0063, "edit");
        // Lock sources in turn, register lock last
        for (int i = 0; i < 4; i++)
        begin
            {pf_recovery, sensor_fail_close, shutter_open} <= 3'b001 << i;
            if (i == 3)
                axi_wr(OFF_CTRL, 32'h1);
            repeat (12) @(posedge clk_sys);
            tap(B_INC, 16'h0063, "locked");
        end
        axi_wr(OFF_CTRL, 32'h0);
        repeat (220) @(posedge clk_sys);
        chk("idle to layer", 10'h001, page_led);
        axi_wr(OFF_SEL, 32'h1);
        axi_rd(OFF_PARAM);
        chk("edit dropped", 16'h0064, rd);
        tap(B_INC, 0, "layer one");
        pm.press(B_DATA, 8);
        chk("single layer", 0, seq_active);
        tap(B_DEC, 16'h0063, "edit");
        pm.press(B_DATA, 8);
        chk("z page", 10'h004, page_led);
        axi_rd(OFF_PARAM);
        chk("stored", 16'h0063, rd);
        repeat (220) @(posedge clk_sys);
        chk("idle to rate", 10'h200, page_led);
        goto(5);
        chk("crystal", 1, shown_value);
        tap(B_INC, 2, "crystal two");
        tap(B_INC, 1, "crystal wrap up");
        tap(B_DEC, 2, "crystal wrap down");
        goto(2);
        pm.press(B_DEC, 45);
        chk("repeat", 1, shown_value < 16'h0371);
        pm.press(B_DATA, 50);
        chk("held data", 0, page_led[3:2] != 2'b00);
        axi_rd(8'h20);
        chk("unmapped resp", RESP_SLVERR, rr);
        chk("unmapped data", 0, rd);
        nvm_fault <= 1'b1;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        nvm_fault <= 1'b0;
        chk("fault flag", 1, memory_fault_code);
        chk("fault code", 16'h00e3, shown_value);
        axi_wr(OFF_SEL, 32'h2);
        axi_rd(OFF_PARAM);
        chk("default z", 16'h0372, rd);
        complete_run();
    end
endmodule // fpmenu_top_tb
